// ### shared/ldc_consts.svh
/*
 * Offsets, field positions and reset values of the display drive control core.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// byte offsets on the register bus
`define LDC_OFS_CONTROL     8'h00
`define LDC_OFS_IRQ_STATUS  8'h04
`define LDC_OFS_IRQ_MASK    8'h08
`define LDC_OFS_BIAS        8'h0C
`define LDC_OFS_STATE       8'h10
`define LDC_OFS_PIXEL_BASE  8'h40
`define LDC_PIXEL_WORDS     16

// display_control fields
`define LDC_BIT_ENABLE      15
`define LDC_BIT_IDLE_STOP   13
`define LDC_BIT_SLEEP_DIS   6
`define LDC_BIT_WRITE_FAIL_ERROR        5
`define LDC_POS_CLKSEL      3
`define LDC_POS_COMMONS     0
`define LDC_CONTROL_WMASK   16'hA05F
`define LDC_CONTROL_RESET   16'h0000

// interrupt status and mask fields
`define LDC_IRQ_WRITE_FAIL  0
`define LDC_IRQ_DRIVE_STOP  1
`define LDC_IRQ_WIDTH       2

// bias codes
`define LDC_BIAS_STATIC     2'h0
`define LDC_BIAS_HALF       2'h1
`define LDC_BIAS_THIRD      2'h2

`endif

// ### shared/ldc_pkg.sv
/*
 * Types of the display drive control core.
 * Assumes ldc_consts.svh sits on the include path.
 */
package ldc_pkg;
	`include "ldc_consts.svh"

	typedef enum logic [2:0] {
		LDC_DRV_OFF  = 3'b001,
		LDC_DRV_RUN  = 3'b010,
		LDC_DRV_HALT = 3'b100
	} ldc_drv_state_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} ldc_ahb_req_t;

	typedef struct packed {
		logic       active;
		logic       tick;
		logic [1:0] clk_src;
		logic [2:0] common_count;
		logic [7:0] backplane_mask;
		logic [1:0] bias;
	} ldc_drive_t;

	typedef struct packed {
		logic        strobe;
		logic [3:0]  index;
		logic [31:0] data;
	} ldc_pixel_wr_t;
endpackage

// ### rtl/ldc_src_sync.sv
/*
 * Clock source picker: brings three slow source clocks into the hclk domain
 * and gives a one-cycle tick on each rising edge of the chosen one.
 * Assumes every source runs well below half of hclk.
 */
module ldc_src_sync (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// source pins
	input  wire logic       frc_clk_in,
	input  wire logic       low_power_rc_clock_clk_in,
	input  wire logic       secondary_oscillator_clk_in,
	// selection and result
	input  wire logic [1:0] sel,
	output logic            tick
);
	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic       last_reg;
	logic       tick_reg;
	wire        chosen;

	// 1x secondary oscillator, 01 low-power rc, 00 fast rc
	assign chosen = sel[1] ? sync_reg[2] : (sel[0] ? sync_reg[1] : sync_reg[0]); // R06
	assign tick   = tick_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			last_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			meta_reg <= {secondary_oscillator_clk_in, low_power_rc_clock_clk_in, frc_clk_in};
			sync_reg <= meta_reg;
			last_reg <= chosen;
			// a switch of source may cost or add one tick; harmless for a glass
			tick_reg <= chosen & ~last_reg;
		end
	end
endmodule

// ### rtl/ldc_drive_ctrl.sv
/*
 * Control core of a segment display driver: control register, bias and
 * interrupt registers behind an AHB-Lite slave, drive state machine and
 * write-failure detection on the pixel data window.
 * Assumes cpu_idle, cpu_sleep and write_allowed_flag come from hclk logic.
 */
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
// Functional notes
// R01: the panel is driven only while display_drive_enable is 1, clearing it disables the driver.
// R02: with idle_stop at 1 driving halts in CPU Idle, with 0 it goes on.
// R03: with sleep_disable at 1 driving stops in Sleep, with 0 it keeps running.
// R04: a pixel_data_reg write while write_allowed_flag is 0 sets write_fail_error.
// R05: only software clears write_fail_error, hardware never does.
// R06: drive_clock_select 1x picks the secondary oscillator, 01 low-power rc, 00 fast rc.
// R07: common_count 000 is static on one line, 001 to 111 mux two to eight lines, 011 up use 1/3 bias.
// R08: unassigned control bits ignore writes and read as zero.
// R09: with two or three commons bias_select 1 gives 1/2 bias and 0 gives 1/3, else keep it 0.
// R10: every control bit resets to zero: disabled, fast rc clock, static drive.
`include "ldc_consts.svh"

module ldc_drive_ctrl
	import ldc_pkg::*;
(
	// clock and reset
	input  wire logic              hclk,
	input  wire logic              hresetn,
	// ahb-lite slave
	input  wire ldc_pkg::ldc_ahb_req_t ahb_req,
	input  wire logic [31:0]       hwdata,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// power modes and phase status
	input  wire logic              cpu_idle,
	input  wire logic              cpu_sleep,
	input  wire logic              write_allowed_flag,
	// clock source pins
	input  wire logic              frc_clk_in,
	input  wire logic              low_power_rc_clock_clk_in,
	input  wire logic              secondary_oscillator_clk_in,
	// panel side
	output ldc_pkg::ldc_drive_t    drive,
	output ldc_pkg::ldc_pixel_wr_t pixel_wr,
	// interrupt
	output logic                   irq
);
	import ldc_pkg::*;

	// bias code from the commons in use; bias_select only counts for two or three
	function automatic logic [1:0] bias_of(input logic [2:0] commons, input logic sel);
		if (commons == 3'h0)
			bias_of = `LDC_BIAS_STATIC;
		else if (commons <= 3'h2 && sel)
			bias_of = `LDC_BIAS_HALF;
		else
			bias_of = `LDC_BIAS_THIRD;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	logic [15:0]           control_reg;
	logic [15:0]           control_next;
	logic [`LDC_IRQ_WIDTH-1:0] status_reg;
	logic [`LDC_IRQ_WIDTH-1:0] status_next;
	logic [`LDC_IRQ_WIDTH-1:0] mask_reg;
	logic [`LDC_IRQ_WIDTH-1:0] mask_next;
	logic                  bias_sel_reg;
	logic                  bias_sel_next;
	logic                  dp_write_reg;
	logic [7:0]            dp_addr_reg;
	logic [31:0]           hrdata_reg;
	ldc_drv_state_t        state_reg;
	ldc_drv_state_t        state_next;
	ldc_drive_t            drive_reg;
	ldc_pixel_wr_t         pixel_reg;
	logic                  src_tick;

	// address phase and data phase decode
	wire       ap_valid   = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
	wire [7:0] ap_addr    = ahb_req.haddr[7:0];
	wire       ap_read    = ap_valid & ~ahb_req.hwrite;
	wire       wr_control = dp_write_reg & hit(dp_addr_reg, `LDC_OFS_CONTROL);
	wire       wr_status  = dp_write_reg & hit(dp_addr_reg, `LDC_OFS_IRQ_STATUS);
	wire       wr_mask    = dp_write_reg & hit(dp_addr_reg, `LDC_OFS_IRQ_MASK);
	wire       wr_bias    = dp_write_reg & hit(dp_addr_reg, `LDC_OFS_BIAS);
	wire       in_pixel   = dp_addr_reg >= `LDC_OFS_PIXEL_BASE &&
	                        dp_addr_reg < (`LDC_OFS_PIXEL_BASE + 8'(4 * `LDC_PIXEL_WORDS));
	wire       wr_pixel   = dp_write_reg & in_pixel;
	wire       write_fail = wr_pixel & ~write_allowed_flag; // R04

	// control fields
	wire       en_bit     = control_reg[`LDC_BIT_ENABLE];
	wire       idle_stop  = control_reg[`LDC_BIT_IDLE_STOP];
	wire       sleep_dis  = control_reg[`LDC_BIT_SLEEP_DIS];
	wire [1:0] clk_sel    = control_reg[`LDC_POS_CLKSEL +: 2];
	wire [2:0] commons    = control_reg[`LDC_POS_COMMONS +: 3];
	wire       mode_hold  = (cpu_idle & idle_stop) | (cpu_sleep & sleep_dis); // R02 R03
	wire       stop_event = (state_reg == LDC_DRV_RUN) && (state_next != LDC_DRV_RUN);

	// control register: writable bits under mask, error flag write-zero-to-clear
	wire [15:0] ctl_written = (hwdata[15:0] & `LDC_CONTROL_WMASK) |
	                          {10'h000, control_reg[`LDC_BIT_WRITE_FAIL_ERROR] & hwdata[`LDC_BIT_WRITE_FAIL_ERROR], 5'h00};
	wire [15:0] ctl_base    = wr_control ? ctl_written : control_reg; // R08 R05
	assign control_next = ctl_base | {10'h000, write_fail, 5'h00}; // R04

	// interrupt status: set wins over write-one-to-clear
	wire [`LDC_IRQ_WIDTH-1:0] irq_events = {stop_event, write_fail};
	wire [`LDC_IRQ_WIDTH-1:0] irq_clear  = wr_status ? hwdata[`LDC_IRQ_WIDTH-1:0] : '0;
	assign status_next   = (status_reg & ~irq_clear) | irq_events;
	assign mask_next     = wr_mask ? hwdata[`LDC_IRQ_WIDTH-1:0] : mask_reg;
	assign bias_sel_next = wr_bias ? hwdata[0] : bias_sel_reg;

	// drive state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LDC_DRV_OFF: begin
				if (en_bit)
					state_next = mode_hold ? LDC_DRV_HALT : LDC_DRV_RUN;
			end
			LDC_DRV_RUN: begin
				if (!en_bit)
					state_next = LDC_DRV_OFF; // R01
				else if (mode_hold)
					state_next = LDC_DRV_HALT; // R02 R03
			end
			LDC_DRV_HALT: begin
				if (!en_bit)
					state_next = LDC_DRV_OFF;
				else if (!mode_hold)
					state_next = LDC_DRV_RUN;
			end
			default: state_next = LDC_DRV_OFF;
		endcase
	end

	// read mux looks at next values so a read right after a write sees it
	wire [31:0] rd_control = {16'h0000, control_next};
	wire [31:0] rd_status  = {{(32 - `LDC_IRQ_WIDTH){1'b0}}, status_next};
	wire [31:0] rd_mask    = {{(32 - `LDC_IRQ_WIDTH){1'b0}}, mask_next};
	wire [31:0] rd_bias    = {31'h00000000, bias_sel_next};
	wire [31:0] rd_state   = {27'h0000000, write_allowed_flag, 1'b0, state_next};
	wire [31:0] rd_data    = hit(ap_addr, `LDC_OFS_CONTROL)    ? rd_control :
	                         hit(ap_addr, `LDC_OFS_IRQ_STATUS) ? rd_status  :
	                         hit(ap_addr, `LDC_OFS_IRQ_MASK)   ? rd_mask    :
	                         hit(ap_addr, `LDC_OFS_BIAS)       ? rd_bias    :
	                         hit(ap_addr, `LDC_OFS_STATE)      ? rd_state   : 32'h00000000;

	// drive outputs
	wire [2:0] multiplex_top = commons; // R07
	wire [7:0] bp_mask       = 8'((9'h002 << multiplex_top) - 9'h001); // R07
	wire       run_next      = (state_next == LDC_DRV_RUN);

	ldc_src_sync u_src_sync (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.frc_clk_in  (frc_clk_in),
		.low_power_rc_clock_clk_in (low_power_rc_clock_clk_in),
		.secondary_oscillator_clk_in (secondary_oscillator_clk_in),
		.sel         (clk_sel),
		.tick        (src_tick)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_reg  <= `LDC_CONTROL_RESET; // R10
			status_reg   <= '0;
			mask_reg     <= '0;
			bias_sel_reg <= 1'b0;
			state_reg    <= LDC_DRV_OFF;
		end else begin
			control_reg  <= control_next;
			status_reg   <= status_next;
			mask_reg     <= mask_next;
			bias_sel_reg <= bias_sel_next;
			state_reg    <= state_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 8'h00;
			hrdata_reg   <= 32'h00000000;
		end else begin
			dp_write_reg <= ap_valid & ahb_req.hwrite;
			dp_addr_reg  <= ap_addr;
			if (ap_read)
				hrdata_reg <= rd_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_reg <= '0;
			pixel_reg <= '0;
		end else begin
			drive_reg.active         <= run_next; // R01
			drive_reg.tick           <= src_tick & run_next; // R06
			drive_reg.clk_src        <= control_next[`LDC_POS_CLKSEL +: 2];
			drive_reg.common_count   <= control_next[`LDC_POS_COMMONS +: 3];
			drive_reg.backplane_mask <= run_next ? bp_mask : 8'h00;
			drive_reg.bias           <= bias_of(commons, bias_sel_reg); // R09
			pixel_reg.strobe         <= wr_pixel & write_allowed_flag;
			pixel_reg.index          <= dp_addr_reg[5:2];
			pixel_reg.data           <= hwdata;
		end
	end

	assign hrdata    = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign drive     = drive_reg;
	assign pixel_wr  = pixel_reg;
	assign irq       = |(status_reg & mask_reg);
endmodule

// ### tb/ldc_drive_ctrl_assertions.sv
/* port checker of the drive control core.
 * assumes it is bound onto every ldc_drive_ctrl. */
`include "ldc_consts.svh"

module ldc_drive_ctrl_assertions
	import ldc_pkg::*;
(
	// clock and reset
	input wire logic                   hclk,
	input wire logic                   hresetn,
	// watched ports
	input wire ldc_pkg::ldc_ahb_req_t  ahb_req,
	input wire logic                   write_allowed_flag,
	input wire ldc_pkg::ldc_drive_t    drive,
	input wire ldc_pkg::ldc_pixel_wr_t pixel_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic written_reg;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// reset values only hold until software writes anything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			written_reg <= 1'b0;
		else if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite)
			written_reg <= 1'b1;
	end
	a_off_no_mask: assert property (
		!drive.active |-> drive.backplane_mask == 8'h00) else $error("lines driven while off");
	a_tick_in_run: assert property (
		drive.tick |-> drive.active || $past(drive.active)) else $error("tick while off");
	a_tick_single: assert property (
		drive.tick |=> !drive.tick) else $error("tick longer than a cycle");
	a_mask_width: assert property (
		drive.active && $past(drive.active) && $stable(drive.common_count)
		|-> drive.backplane_mask == 8'((9'h002 << drive.common_count) - 9'h001))
		else $error("wrong backplane lines");
	a_bias_third: assert property (
		(drive.common_count >= 3'h3)[*3] |-> drive.bias == `LDC_BIAS_THIRD)
		else $error("many commons not third bias");
	a_bias_static: assert property (
		(drive.common_count == 3'h0)[*3] |-> drive.bias == `LDC_BIAS_STATIC)
		else $error("static drive not static bias");
	a_half_bias: assert property (
		drive.bias == `LDC_BIAS_HALF |-> drive.common_count inside {3'h1, 3'h2}
		|| $past(drive.common_count) inside {3'h1, 3'h2}) else $error("half bias misplaced");
	a_pixel_allowed: assert property (
		pixel_wr.strobe |-> $past(write_allowed_flag)) else $error("pixel passed while barred");
	a_reset_values: assert property (
		!written_reg |-> !drive.active && drive.clk_src == 2'h0 && drive.common_count == 3'h0)
		else $error("control not at reset value");
endmodule

bind ldc_drive_ctrl ldc_drive_ctrl_assertions u_chk (
	.hclk, .hresetn, .ahb_req, .write_allowed_flag, .drive, .pixel_wr);

// ### tb/ldc_panel_model.sv
/* panel model: counts frame steps, keeps the last accepted pixel word.
 * assumes drive and pixel_wr come straight from the core. */
module ldc_panel_model
	import ldc_pkg::*;
(
	input  wire logic                   hclk,
	input  wire ldc_pkg::ldc_drive_t    drive,
	input  wire ldc_pkg::ldc_pixel_wr_t pixel_wr,
	input  wire logic                   tick_clear,
	output int                          tick_count,
	output ldc_pkg::ldc_pixel_wr_t      last_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial tick_count = 0;
	initial last_wr = '0;
	always @(posedge hclk) begin
		if (tick_clear)
			tick_count <= 0;
		// glass only steps while it is really driven
		else if (drive.tick && drive.active)
			tick_count <= tick_count + 1;
		if (pixel_wr.strobe)
			last_wr <= pixel_wr;
	end
endmodule

// ### tb/lcd_drive_control_tb_top.sv
/* self-checking bench of the drive control core.
 * assumes the checker and panel model are compiled alongside. */
`include "ldc_consts.svh"

module lcd_drive_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ldc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hreadyout, hresp, irq, tick_clear = 1'b0;
	logic cpu_idle = 1'b0, cpu_sleep = 1'b0, write_allowed_flag = 1'b0;
	logic frc_clk_in = 1'b0, low_power_rc_clock_clk_in = 1'b0, secondary_oscillator_clk_in = 1'b0;
	logic [31:0] hwdata = '0, hrdata, q;
	ldc_ahb_req_t req = '0, ahb_w;
	ldc_drive_t drive;
	ldc_pixel_wr_t pixel_wr, last_wr;
	int tick_count, fail_count = 0, comparisons = 0;
	assign ahb_w = {req[39:1], hreadyout};
	always #5 hclk = ~hclk;
	// source periods kept off the hclk grid
	always #41 frc_clk_in = ~frc_clk_in;
	always #101 low_power_rc_clock_clk_in = ~low_power_rc_clock_clk_in;
	always #151 secondary_oscillator_clk_in = ~secondary_oscillator_clk_in;
	ldc_drive_ctrl dut (.hclk, .hresetn, .ahb_req(ahb_w), .hwdata, .hrdata, .hreadyout,
		.hresp, .cpu_idle, .cpu_sleep, .write_allowed_flag, .frc_clk_in, .low_power_rc_clock_clk_in,
		.secondary_oscillator_clk_in, .drive, .pixel_wr, .irq);
	ldc_panel_model panel (.hclk, .drive, .pixel_wr, .tick_clear, .tick_count, .last_wr);
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		req.hsel <= 1'b1;
		req.haddr <= {24'h0, a};
		req.htrans <= 2'h2;
		req.hwrite <= w;
		req.hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		req.htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic settle;
		repeat (4) @(posedge hclk);
	endtask
	task automatic mode(input logic i, s, e);
		@(posedge hclk);
		cpu_idle <= i;
		cpu_sleep <= s;
		settle;
		chk("active", drive.active, e);
	endtask
	task automatic t_reset;
		bus(0, 8'h00, 0);
		chk("control", q, 32'h0);
		chk("hresp", hresp, 0);
		bus(0, 8'h10, 0);
		chk("state", q, 32'h1);
		bus(1, 8'h00, 32'hFFFF_FFFF);
		bus(0, 8'h00, 0);
		chk("control", q, 32'h0000_A05F);
		bus(1, 8'h00, 0);
		bus(1, 8'h20, 32'hFFFF_FFFF);
		bus(0, 8'h20, 0);
		chk("unmapped", q, 32'h0);
		$display("test reset and registers done");
	endtask
	task automatic t_mux;
		for (int b = 0; b < 2; b++) begin
			for (int c = 0; c < 8; c++) begin
				// bias_select may be 1 only while two or three commons are in use
				bus(1, 8'h0C, 0);
				bus(1, 8'h00, 32'h8000 | c);
				bus(1, 8'h0C, (c == 1 || c == 2) ? b : 0);
				settle;
				chk("active", drive.active, 1);
				chk("commons", drive.common_count, c);
				chk("mask", drive.backplane_mask, 32'((1 << (c + 1)) - 1));
				q = (c < 3 && b == 1) ? `LDC_BIAS_HALF : `LDC_BIAS_THIRD;
				chk("bias", drive.bias, c == 0 ? `LDC_BIAS_STATIC : q);
			end
		end
		bus(1, 8'h0C, 0);
		for (int s = 0; s < 4; s++) begin
			bus(1, 8'h00, 32'h8000 | (s << 3));
			settle;
			chk("clk_src", drive.clk_src, s);
			@(posedge hclk) tick_clear <= 1'b1;
			@(posedge hclk) tick_clear <= 1'b0;
			repeat (600) @(posedge hclk);
			q = 6000 / (s == 0 ? 82 : s == 1 ? 202 : 302);
			chk("tick rate", tick_count >= q - 1 && tick_count <= q + 1, 1);
		end
		bus(1, 8'h00, 0);
		settle;
		chk("active", drive.active, 0);
		$display("test mux bias and clock done");
	endtask
	task automatic t_modes;
		bus(1, 8'h04, 3);
		bus(1, 8'h00, 32'hA040);
		mode(1, 0, 0);
		bus(0, 8'h04, 0);
		chk("stop event", q[1], 1);
		mode(0, 0, 1);
		mode(0, 1, 0);
		bus(1, 8'h00, 32'h8000);
		mode(1, 1, 1);
		mode(0, 0, 1);
		$display("test idle and sleep done");
	endtask
	task automatic t_write_fail_error;
		bus(1, 8'h00, 0);
		bus(1, 8'h04, 3);
		bus(1, 8'h08, 1);
		bus(1, 8'h44, 32'h1234_5678);
		bus(0, 8'h00, 0);
		chk("write fail", q, 32'h20);
		chk("irq", irq, 1);
		chk("refused pixel", last_wr.strobe, 0);
		@(posedge hclk) write_allowed_flag <= 1'b1;
		bus(1, 8'h48, 32'hCAFE_0001);
		settle;
		chk("pixel index", last_wr.index, 4'h2);
		chk("pixel data", last_wr.data, 32'hCAFE_0001);
		bus(0, 8'h00, 0);
		chk("write fail kept", q, 32'h20);
		bus(1, 8'h00, 0);
		bus(1, 8'h04, 1);
		bus(0, 8'h00, 0);
		chk("write fail cleared", q, 32'h0);
		chk("irq", irq, 0);
		bus(1, 8'h08, 0);
		@(posedge hclk) write_allowed_flag <= 1'b0;
		bus(1, 8'h40, 32'h5);
		bus(0, 8'h04, 0);
		chk("status", q[0], 1);
		chk("masked irq", irq, 0);
		$display("test write failure done");
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_mux;
		t_modes;
		t_write_fail_error;
		summarize;
	end
	initial begin
		#200000;
		fail_count++;
		summarize;
	end
endmodule
